// file: core/pllld_regs.vh
// Register map, field positions, reset values and timing constants of the PLL lock-detect block.
`ifndef PLLLD_REGS_VH
`define PLLLD_REGS_VH

`define PLLLD_ADDR_W            8
`define PLLLD_OFF_CFG           8'h18
`define PLLLD_OFF_ANTIBL        8'h1C
`define PLLLD_OFF_STATE         8'h20
`define PLLLD_OFF_INT_STATUS    8'h24
`define PLLLD_OFF_INT_ENABLE    8'h28
`define PLLLD_OFF_INT_CLEAR     8'h2C

`define PLLLD_CFG_RESET         8'h06
`define PLLLD_CFG_WMASK         8'hFE
`define PLLLD_CFG_DCOFF_BIT     7
`define PLLLD_CFG_LDCNT_HI      6
`define PLLLD_CFG_LDCNT_LO      5
`define PLLLD_CFG_WINLOW_BIT    4
`define PLLLD_CFG_DISABLE_BIT   3
`define PLLLD_CFG_CALDIV_HI     2
`define PLLLD_CFG_CALDIV_LO     1
`define PLLLD_ANTIBL_RESET      2'h0

`define PLLLD_INT_W             2
`define PLLLD_INT_GAIN_BIT      0
`define PLLLD_INT_LOSS_BIT      1

`define PLLLD_LOCK_CNT_00       8'h05
`define PLLLD_LOCK_CNT_01       8'h10
`define PLLLD_LOCK_CNT_10       8'h40
`define PLLLD_LOCK_CNT_11       8'hFF

`define PLLLD_ABW_00_PS         13'h0B54
`define PLLLD_ABW_01_PS         13'h0514
`define PLLLD_ABW_10_PS         13'h1770
`define PLLLD_ABW_11_PS         13'h0B54

`define PLLLD_CLK_PERIOD_PS     20000
`define PLLLD_WIN_HI_PS         3500
`define PLLLD_WIN_LO_PS         1000
`define PLLLD_LOSS_HI_PS        7000
`define PLLLD_LOSS_LO_PS        3000
`define PLLLD_DIFF_MAX          8'hFF

`endif

// file: core/pllld_cal_divider.v
// Divider that derives the VCO calibration clock from the reference clock.
`timescale 1ns/10ps
module pllld_cal_divider #(
    parameter CNT_W = 4
) (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       ce,
    input  wire [1:0] divSel,
    output reg        calClk
);

    reg  [CNT_W-1:0] divCnt;
    wire [CNT_W-1:0] next_divCnt;

    assign next_divCnt = divCnt + {{(CNT_W-1){1'b0}}, 1'b1};

    // Bit k of a free-running counter has period 2^(k+1), so the select picks 2, 4, 8 or 16.
    always @(posedge ref_clk) begin
        if (rst) begin
            divCnt <= {CNT_W{1'b0}};
            calClk <= 1'b0;
        end else if (ce) begin
            divCnt <= next_divCnt;
            calClk <= next_divCnt[divSel];
        end
    end

endmodule // pllld_cal_divider

// file: core/pllld_lock_detect.v
// PLL digital lock detector, calibration clock divider and configuration registers on APB.
// Behaviour
// - Two-bit code picks antibacklash pulse width.
// - Bit 7 enables reference dc offset.
// - Lock needs 5, 16, 64 or 255 cycles.
// - Rising edges closer than window count.
// - Lock holds until loss threshold exceeded.
// - Bit 4 selects high or low window.
// - Bit 3 disables the lock detector.
// - Field [2:1] divides calibration clock 2/4/8.
// - Code 11 divides by 16, reset default.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`include "pllld_regs.vh"
module pllld_lock_detect #(
    parameter WIN_HI_PS  = `PLLLD_WIN_HI_PS,
    parameter WIN_LO_PS  = `PLLLD_WIN_LO_PS,
    parameter LOSS_HI_PS = `PLLLD_LOSS_HI_PS,
    parameter LOSS_LO_PS = `PLLLD_LOSS_LO_PS
) (
    input  wire                     ref_clk,
    input  wire                     rst,
    input  wire                     ce,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`PLLLD_ADDR_W-1:0] paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output wire                     pready,
    output wire                     pslverr,
    input  wire                     pfdRefIn,
    input  wire                     pfdFbIn,
    output reg                      digitalLockFlag,
    output reg                      refDcOffsetEn,
    output reg  [1:0]               antibacklashSel,
    output reg  [12:0]              antibacklashPs,
    output wire                     calClk,
    output wire                     irq
);

    localparam ST_IDLE     = 2'b00;
    localparam ST_WAIT_FB  = 2'b01;
    localparam ST_WAIT_REF = 2'b10;

    // A least time rounds up to whole cycles, never below one.
    function [7:0] cycCeil;
        input integer ps;
        integer c;
        begin
            c = (ps + `PLLLD_CLK_PERIOD_PS - 1) / `PLLLD_CLK_PERIOD_PS;
            if (c < 1)
                c = 1;
            if (c > 255)
                c = 255;
            cycCeil = c[7:0];
        end
    endfunction

    // A longest time rounds down to whole cycles, never below one.
    function [7:0] cycFloor;
        input integer ps;
        integer c;
        begin
            c = ps / `PLLLD_CLK_PERIOD_PS;
            if (c < 1)
                c = 1;
            if (c > 255)
                c = 255;
            cycFloor = c[7:0];
        end
    endfunction

    function [7:0] satInc;
        input [7:0] v;
        begin
            satInc = (v == `PLLLD_DIFF_MAX) ? v : v + 8'h01;
        end
    endfunction

    function [7:0] lockTarget;
        input [1:0] code;
        begin
            case (code)
                2'b00:   lockTarget = `PLLLD_LOCK_CNT_00;
                2'b01:   lockTarget = `PLLLD_LOCK_CNT_01;
                2'b10:   lockTarget = `PLLLD_LOCK_CNT_10;
                default: lockTarget = `PLLLD_LOCK_CNT_11;
            endcase
        end
    endfunction

    function [12:0] abWidth;
        input [1:0] code;
        begin
            case (code)
                2'b00:   abWidth = `PLLLD_ABW_00_PS;
                2'b01:   abWidth = `PLLLD_ABW_01_PS;
                2'b10:   abWidth = `PLLLD_ABW_10_PS;
                default: abWidth = `PLLLD_ABW_11_PS;
            endcase
        end
    endfunction

    localparam [7:0] WIN_HI_CYC  = cycCeil(WIN_HI_PS);
    localparam [7:0] WIN_LO_CYC  = cycCeil(WIN_LO_PS);
    localparam [7:0] LOSS_HI_CYC = cycFloor(LOSS_HI_PS);
    localparam [7:0] LOSS_LO_CYC = cycFloor(LOSS_LO_PS);

    reg  [7:0]              cfgReg;
    reg  [`PLLLD_INT_W-1:0] intStatus;
    reg  [`PLLLD_INT_W-1:0] intEnable;
    reg                     apbLoaded;
    reg                     refSync1;
    reg                     refSync2;
    reg                     refPrev;
    reg                     fbSync1;
    reg                     fbSync2;
    reg                     fbPrev;
    reg  [1:0]              state;
    reg  [1:0]              next_state;
    reg  [7:0]              diffCnt;
    reg  [7:0]              next_diffCnt;
    reg                     pairDone;
    reg  [7:0]              pairDiff;
    reg  [7:0]              lockCnt;
    reg                     lockPrev;
    reg  [31:0]             readMux;
    reg                     addrHit;
    wire                    refRise;
    wire                    fbRise;
    wire                    detDisable;
    wire [7:0]              winCyc;
    wire [7:0]              lossCyc;
    wire [7:0]              target;
    wire                    inWindow;
    wire                    lossSeen;
    wire                    apbAccess;
    wire                    apbWrite;
    wire [`PLLLD_INT_W-1:0] intEvents;
    wire [`PLLLD_INT_W-1:0] intClear;

    assign detDisable = cfgReg[`PLLLD_CFG_DISABLE_BIT];
    assign winCyc     = cfgReg[`PLLLD_CFG_WINLOW_BIT] ? WIN_LO_CYC : WIN_HI_CYC;
    assign lossCyc    = cfgReg[`PLLLD_CFG_WINLOW_BIT] ? LOSS_LO_CYC : LOSS_HI_CYC;
    assign target     = lockTarget(cfgReg[`PLLLD_CFG_LDCNT_HI:`PLLLD_CFG_LDCNT_LO]);
    assign inWindow   = pairDiff < winCyc;
    assign lossSeen   = pairDiff > lossCyc;

    // Both detector inputs are pins from another domain; the first stage feeds only the second.
    always @(posedge ref_clk) begin
        if (rst) begin
            refSync1 <= 1'b0;
            refSync2 <= 1'b0;
            refPrev  <= 1'b0;
            fbSync1  <= 1'b0;
            fbSync2  <= 1'b0;
            fbPrev   <= 1'b0;
        end else if (ce) begin
            refSync1 <= pfdRefIn;
            refSync2 <= refSync1;
            refPrev  <= refSync2;
            fbSync1  <= pfdFbIn;
            fbSync2  <= fbSync1;
            fbPrev   <= fbSync2;
        end
    end

    assign refRise = refSync2 & ~refPrev;
    assign fbRise  = fbSync2 & ~fbPrev;

    // Pairs the rising edges of the two inputs and measures their distance in clock cycles.
    // An edge repeated on the leading input, or a pair that never closes, scores the maximum.
    always @* begin
        next_state   = state;
        next_diffCnt = diffCnt;
        pairDone     = 1'b0;
        pairDiff     = `PLLLD_DIFF_MAX;
        case (state)
            ST_IDLE: begin
                if (refRise && fbRise) begin
                    pairDone = 1'b1;
                    pairDiff = 8'h00;
                end else if (refRise) begin
                    next_state   = ST_WAIT_FB;
                    next_diffCnt = 8'h00;
                end else if (fbRise) begin
                    next_state   = ST_WAIT_REF;
                    next_diffCnt = 8'h00;
                end
            end
            ST_WAIT_FB: begin
                next_diffCnt = satInc(diffCnt);
                if (fbRise) begin
                    pairDone   = 1'b1;
                    pairDiff   = satInc(diffCnt);
                    next_state = refRise ? ST_WAIT_FB : ST_IDLE;
                    next_diffCnt = 8'h00;
                end else if (refRise) begin
                    pairDone     = 1'b1;
                    next_diffCnt = 8'h00;
                end else if (diffCnt == `PLLLD_DIFF_MAX) begin
                    pairDone   = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_WAIT_REF: begin
                next_diffCnt = satInc(diffCnt);
                if (refRise) begin
                    pairDone   = 1'b1;
                    pairDiff   = satInc(diffCnt);
                    next_state = fbRise ? ST_WAIT_REF : ST_IDLE;
                    next_diffCnt = 8'h00;
                end else if (fbRise) begin
                    pairDone     = 1'b1;
                    next_diffCnt = 8'h00;
                end else if (diffCnt == `PLLLD_DIFF_MAX) begin
                    pairDone   = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state   = ST_IDLE;
                next_diffCnt = 8'h00;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state   <= ST_IDLE;
            diffCnt <= 8'h00;
        end else if (ce) begin
            state   <= next_state;
            diffCnt <= next_diffCnt;
        end
    end

    // Lock needs a run of good cycles; once held it drops only past the wider loss threshold or when the detector is disabled.
    always @(posedge ref_clk) begin
        if (rst) begin
            lockCnt         <= 8'h00;
            digitalLockFlag <= 1'b0;
        end else if (ce) begin
            if (detDisable) begin
                lockCnt         <= 8'h00;
                digitalLockFlag <= 1'b0;
            end else if (pairDone) begin
                if (inWindow) begin
                    lockCnt <= satInc(lockCnt);
                    if (satInc(lockCnt) >= target)
                        digitalLockFlag <= 1'b1;
                end else begin
                    lockCnt <= 8'h00;
                    if (lossSeen)
                        digitalLockFlag <= 1'b0;
                end
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst)
            lockPrev <= 1'b0;
        else if (ce)
            lockPrev <= digitalLockFlag;
    end

    assign intEvents[`PLLLD_INT_GAIN_BIT] = digitalLockFlag & ~lockPrev;
    assign intEvents[`PLLLD_INT_LOSS_BIT] = ~digitalLockFlag & lockPrev;

    pllld_cal_divider #(
        .CNT_W (4)
    ) i_pllld_cal_divider (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .divSel  (cfgReg[`PLLLD_CFG_CALDIV_HI:`PLLLD_CFG_CALDIV_LO]),
        .calClk  (calClk)
    );

    // Read data is captured in the setup cycle so the access phase needs no wait state.
    assign apbAccess = psel & penable & apbLoaded;
    assign pready    = apbLoaded & ce;
    assign pslverr   = pready & penable & ~addrHit;
    assign apbWrite  = apbAccess & ce & pwrite & addrHit;
    assign intClear  = (apbWrite && paddr == `PLLLD_OFF_INT_CLEAR) ? pwdata[`PLLLD_INT_W-1:0]
                                                                   : {`PLLLD_INT_W{1'b0}};
    assign irq       = |(intStatus & intEnable);

    always @* begin
        readMux = 32'h00000000;
        addrHit = 1'b1;
        case (paddr)
            `PLLLD_OFF_CFG:        readMux[7:0] = cfgReg;
            `PLLLD_OFF_ANTIBL:     readMux[1:0] = antibacklashSel;
            `PLLLD_OFF_STATE:      readMux[15:0] = {lockCnt, 7'h00, digitalLockFlag};
            `PLLLD_OFF_INT_STATUS: readMux[`PLLLD_INT_W-1:0] = intStatus;
            `PLLLD_OFF_INT_ENABLE: readMux[`PLLLD_INT_W-1:0] = intEnable;
            `PLLLD_OFF_INT_CLEAR:  readMux = 32'h00000000;
            default:               addrHit = 1'b0;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            apbLoaded <= 1'b0;
            prdata    <= 32'h00000000;
        end else if (ce) begin
            apbLoaded <= psel & ~(penable & apbLoaded);
            if (psel && !apbLoaded)
                prdata <= readMux;
        end
    end

    // Writes to the status registers are ignored; the state register is read-only.
    always @(posedge ref_clk) begin
        if (rst) begin
            cfgReg          <= `PLLLD_CFG_RESET;
            antibacklashSel <= `PLLLD_ANTIBL_RESET;
            intEnable       <= {`PLLLD_INT_W{1'b0}};
        end else if (ce && apbWrite) begin
            if (paddr == `PLLLD_OFF_CFG)
                cfgReg <= pwdata[7:0] & `PLLLD_CFG_WMASK;
            if (paddr == `PLLLD_OFF_ANTIBL)
                antibacklashSel <= pwdata[1:0];
            if (paddr == `PLLLD_OFF_INT_ENABLE)
                intEnable <= pwdata[`PLLLD_INT_W-1:0];
        end
    end

    // A lock event in the same cycle as its clear keeps the bit set.
    always @(posedge ref_clk) begin
        if (rst)
            intStatus <= {`PLLLD_INT_W{1'b0}};
        else if (ce)
            intStatus <= (intStatus & ~intClear) | intEvents;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            refDcOffsetEn  <= 1'b0;
            antibacklashPs <= `PLLLD_ABW_00_PS;
        end else if (ce) begin
            refDcOffsetEn  <= cfgReg[`PLLLD_CFG_DCOFF_BIT];
            antibacklashPs <= abWidth(antibacklashSel);
        end
    end

endmodule // pllld_lock_detect

// file: verif/pllld_lock_detect_assertions.sv
// Port-level concurrent checks for the PLL lock-detect block.
`timescale 1ns/10ps
`include "pllld_regs.vh"
module pllld_lock_detect_assertions (
    input wire        ref_clk,
    input wire        rst,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        pfdRefIn,
    input wire        pfdFbIn,
    input wire        digitalLockFlag,
    input wire        refDcOffsetEn,
    input wire [1:0]  antibacklashSel,
    input wire [12:0] antibacklashPs,
    input wire        calClk,
    input wire        irq
);
    logic [7:0]  cfg;
    logic [7:0]  cfgAge;
    logic [7:0]  pairCnt;
    logic [7:0]  loneAge;
    logic [3:0]  sinceTog;
    logic        calPrev;
    logic        wrCfg;
    logic        mapped;
    logic [7:0]  need;
    logic [12:0] abw;

    assign wrCfg = psel && penable && pwrite && pready && paddr == `PLLLD_OFF_CFG;
    assign mapped = paddr inside {`PLLLD_OFF_CFG, `PLLLD_OFF_ANTIBL, `PLLLD_OFF_STATE,
                                  `PLLLD_OFF_INT_STATUS, `PLLLD_OFF_INT_ENABLE, `PLLLD_OFF_INT_CLEAR};
    assign need = cfg[6] ? (cfg[5] ? `PLLLD_LOCK_CNT_11 : `PLLLD_LOCK_CNT_10)
                         : (cfg[5] ? `PLLLD_LOCK_CNT_01 : `PLLLD_LOCK_CNT_00);
    assign abw = antibacklashSel[1] ? (antibacklashSel[0] ? `PLLLD_ABW_11_PS : `PLLLD_ABW_10_PS)
                                    : (antibacklashSel[0] ? `PLLLD_ABW_01_PS : `PLLLD_ABW_00_PS);

    // Shadow of the pin traffic; a lone edge is any edge without a same-cycle partner.
    always @(posedge ref_clk) begin
        calPrev <= calClk;
        sinceTog <= (calClk != calPrev) ? 4'h0 : sinceTog + 4'h1;
        cfgAge <= (rst || wrCfg || !ce) ? 8'h00 : cfgAge + {7'h00, cfgAge != 8'hFF};
        if (rst)
            loneAge <= 8'hFF;
        else if ($rose(pfdRefIn) != $rose(pfdFbIn))
            loneAge <= 8'h00;
        else if (loneAge != 8'hFF)
            loneAge <= loneAge + 8'h01;
        if (rst)
            cfg <= `PLLLD_CFG_RESET;
        else if (wrCfg)
            cfg <= pwdata[7:0] & `PLLLD_CFG_WMASK;
        if (rst || cfg[3] || $rose(pfdRefIn) != $rose(pfdFbIn))
            pairCnt <= 8'h00;
        else if ($rose(pfdRefIn) && pairCnt != 8'hFF)
            pairCnt <= pairCnt + 8'h01;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence setupPh;
        psel && !penable && ce;
    endsequence
    sequence accessPh;
        psel && penable && ce;
    endsequence

    AST_RESET_STATE: assert property (
        $fell(rst) |-> !digitalLockFlag && !refDcOffsetEn && antibacklashPs == `PLLLD_ABW_00_PS)
        else $error("outputs not at reset values");
    AST_APB_ZERO_WAIT: assert property (setupPh ##1 accessPh |-> pready)
        else $error("ready missing in first access cycle");
    AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address map");
    AST_ABW_WIDTH: assert property (
        $stable(antibacklashSel) && $past(ce) |-> antibacklashPs == abw)
        else $error("pulse width does not match code");
    AST_DC_OFFSET: assert property (
        wrCfg |-> ##2 refDcOffsetEn == $past(pwdata[7], 2))
        else $error("offset enable does not follow bit 7");
    AST_DISABLED_LOW: assert property (
        cfg[3] && $past(cfg[3]) && $past(ce) |-> !digitalLockFlag)
        else $error("lock flag high while detector disabled");
    AST_LOCK_COUNT: assert property (
        $rose(digitalLockFlag) |-> pairCnt >= need)
        else $error("lock reported before enough aligned cycles");
    AST_LOSS_HOLD: assert property (
        $fell(digitalLockFlag) |-> cfg[3] || loneAge < 8'h08)
        else $error("lock dropped without a late edge");
    AST_CAL_PERIOD: assert property (
        calClk != calPrev && cfgAge > 8'h20 |-> sinceTog == (4'h1 << cfg[2:1]) - 4'h1)
        else $error("calibration clock half period wrong");
endmodule // pllld_lock_detect_assertions

bind pllld_lock_detect pllld_lock_detect_assertions i_pllld_lock_detect_assertions (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pfdRefIn(pfdRefIn), .pfdFbIn(pfdFbIn), .digitalLockFlag(digitalLockFlag),
    .refDcOffsetEn(refDcOffsetEn), .antibacklashSel(antibacklashSel),
    .antibacklashPs(antibacklashPs), .calClk(calClk), .irq(irq));

// file: verif/test_pll_lock_detect_config.sv
// Self-checking testbench for the PLL lock-detect block.
`timescale 1ns/10ps
module test_pll_lock_detect_config;
    logic        ref_clk;
    logic        rst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic        pfdRefIn;
    logic        pfdFbIn;
    wire         digitalLockFlag;
    wire         refDcOffsetEn;
    wire  [1:0]  antibacklashSel;
    wire  [12:0] antibacklashPs;
    wire         calClk;
    wire         irq;
    integer      miscompares;
    integer      cmpCount;
    integer      p;
    logic [31:0] rd;
    logic        err;
    logic        v;
    localparam logic [12:0] ABW [4] = '{13'h0B54, 13'h0514, 13'h1770, 13'h0B54};
    localparam logic [7:0]  LCK [4] = '{8'h05, 8'h10, 8'h40, 8'hFF};

    pllld_lock_detect i_pllld_lock_detect (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pfdRefIn(pfdRefIn), .pfdFbIn(pfdFbIn), .digitalLockFlag(digitalLockFlag),
        .refDcOffsetEn(refDcOffsetEn), .antibacklashSel(antibacklashSel),
        .antibacklashPs(antibacklashPs), .calClk(calClk), .irq(irq));

    task printVerdict;
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task tmo;
        miscompares = miscompares + 1;
        printVerdict;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        cmpCount = cmpCount + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask

    // An idle edge opens every transfer so psel never gets two updates in one step.
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            cyc(1);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            cyc(1);
            penable <= 1'h1;
            k = 0;
            // Ready, read data and error are taken at the same rising edge that completes the access.
            do begin
                cyc(1);
                k = k + 1;
            end while (pready !== 1'h1 && k < 64);
            if (pready !== 1'h1) tmo;
            rd = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(1'h1, a, d);
    endtask

    task rdChk(input [7:0] a, input [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask

    task pairs(input integer n, input integer lag);
        repeat (n) begin
            pfdRefIn <= 1'h1;
            if (lag > 0) cyc(lag);
            pfdFbIn <= 1'h1;
            cyc(6);
            pfdRefIn <= 1'h0;
            pfdFbIn <= 1'h0;
            cyc(6);
        end
    endtask

    task relock(input [7:0] c);
        wr(8'h18, {24'h0, c | 8'h08});
        wr(8'h18, {24'h0, c});
    endtask

    task rise(output integer k);
        logic last;
        begin
            last = calClk;
            for (k = 1; k < 40; k = k + 1) begin
                cyc(1);
                if (calClk === 1'h1 && last === 1'h0) break;
                last = calClk;
            end
            if (k >= 40) tmo;
        end
    endtask

    task tReset;
        rdChk(8'h18, 32'h06);
        rdChk(8'h1C, 32'h0);
        chk(antibacklashPs, 13'h0B54);
        chk(refDcOffsetEn, 1'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk(err, 1'h1);
        chk(rd, 32'h0);
        $display("test reset finished");
    endtask

    task tAbw;
        for (int i = 0; i < 4; i++) begin
            wr(8'h1C, i);
            cyc(3);
            chk(antibacklashSel, i);
            chk(antibacklashPs, ABW[i]);
        end
        $display("test antibacklash finished");
    endtask

    task tDcOff;
        wr(8'h18, 32'h87);
        cyc(3);
        chk(refDcOffsetEn, 1'h1);
        rdChk(8'h18, 32'h86);
        wr(8'h18, 32'h06);
        cyc(3);
        chk(refDcOffsetEn, 1'h0);
        $display("test offset finished");
    endtask

    task tLockCnt;
        for (int c = 0; c < 4; c++) begin
            relock(8'h06 | (c << 5) | ((c == 1) << 4));
            pairs(LCK[c] - 1, 0);
            chk(digitalLockFlag, 1'h0);
            pairs(1, 0);
            chk(digitalLockFlag, 1'h1);
        end
        $display("test lock count finished");
    endtask

    task tHyst;
        relock(8'h06);
        wr(8'h2C, 32'h3);
        wr(8'h28, 32'h1);
        pairs(5, 0);
        chk(irq, 1'h1);
        rdChk(8'h24, 32'h1);
        wr(8'h28, 32'h0);
        cyc(1);
        chk(irq, 1'h0);
        wr(8'h28, 32'h1);
        wr(8'h2C, 32'h1);
        cyc(1);
        chk(irq, 1'h0);
        pairs(2, 1);
        chk(digitalLockFlag, 1'h1);
        rdChk(8'h20, 32'h1);
        pairs(1, 3);
        chk(digitalLockFlag, 1'h0);
        rdChk(8'h24, 32'h2);
        $display("test hysteresis finished");
    endtask

    task tDisable;
        pairs(5, 0);
        chk(digitalLockFlag, 1'h1);
        wr(8'h18, 32'h0E);
        cyc(2);
        chk(digitalLockFlag, 1'h0);
        pairs(5, 0);
        chk(digitalLockFlag, 1'h0);
        rdChk(8'h20, 32'h0);
        $display("test disable finished");
    endtask

    task tCal;
        ce <= 1'h0;
        cyc(1);
        v = calClk;
        cyc(4);
        chk(calClk, v);
        ce <= 1'h1;
        for (int c = 0; c < 4; c++) begin
            // Detector pairs here come far below 12.5 MHz, so software may pick any divide code.
            wr(8'h18, c << 1);
            cyc(40);
            rise(p);
            rise(p);
            chk(p, 2 << c);
        end
        $display("test divider finished");
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        miscompares = 0;
        cmpCount = 0;
        rst <= 1'h1;
        ce <= 1'h1;
        psel <= 1'h0;
        penable <= 1'h0;
        pwrite <= 1'h0;
        paddr <= 8'h0;
        pwdata <= 32'h0;
        pfdRefIn <= 1'h0;
        pfdFbIn <= 1'h0;
        cyc(16);
        rst <= 1'h0;
        tReset;
        tAbw;
        tDcOff;
        tLockCnt;
        tHyst;
        tDisable;
        tCal;
        printVerdict;
    end
endmodule // test_pll_lock_detect_config
